/* shared/isle_regs.svh */
`ifndef ISLE_REGS_SVH
`define ISLE_REGS_SVH
`define ISLE_INC_SKIP_OPC 6'h0f
`define ISLE_OR_IMM_OPC 4'hd
`define ISLE_OPC6_MSB 11
`define ISLE_OPC6_LSB 6
`define ISLE_OPC4_LSB 8
`define ISLE_TARGET_BIT 5
`define ISLE_ADDR_MSB 4
`define ISLE_IMM_MSB 7
`define ISLE_ACC_RESET 8'h00
`endif

/* shared/isle_pkg.sv */
package isle_pkg;
  typedef enum logic [1:0] {ISLE_IDLE, ISLE_EXEC, ISLE_SKIP} isle_state_e;
  typedef struct packed {
    logic valid;
    logic [11:0] word;
  } isle_instr_s;
  typedef struct packed {
    logic wr_en;
    logic [4:0] addr;
    logic [7:0] data;
  } isle_rf_wr_s;
  typedef struct packed {
    isle_state_e state;
    logic [7:0] acc;
    logic null_result_flag;
    isle_rf_wr_s rf_wr;
    logic skip_active;
    logic retired;
  } isle_state_s;
endpackage

/* verilog/isle_decode.sv */
`include "isle_regs.svh"
module isle_decode (
  input wire logic [11:0] word,
  output logic increment_skip_zero_op,
  output logic or_immediate_op,
  output logic result_target_select,
  output logic [4:0] register_operand,
  output logic [7:0] immediate_value
);
  // [RULE1] Increment-skip decode.
  assign increment_skip_zero_op = word[`ISLE_OPC6_MSB:`ISLE_OPC6_LSB] == `ISLE_INC_SKIP_OPC;
  // [RULE5] OR-immediate decode.
  assign or_immediate_op = word[`ISLE_OPC6_MSB:`ISLE_OPC4_LSB] == `ISLE_OR_IMM_OPC;
  assign result_target_select = word[`ISLE_TARGET_BIT];
  assign register_operand = word[`ISLE_ADDR_MSB:0];
  assign immediate_value = word[`ISLE_IMM_MSB:0];
endmodule // isle_decode

/* verilog/isle_core.sv */
// Behaviour
// [RULE1] Opcode 001111 decodes as increment-and-skip.
// [RULE2] Target bit picks accumulator or register.
// [RULE3] Zero result skips next, two cycles, flags unchanged.
// [RULE4] Skip tests the value actually written.
// [RULE5] Opcode 1101 ORs immediate into accumulator.
// [RULE6] OR result to accumulator, one cycle, flag.
// [RULE7] Flag set on zero; increment wraps.
`include "isle_regs.svh"
module isle_core (
  input wire logic mclk,
  input wire logic reset,
  input wire isle_pkg::isle_instr_s instr,
  input wire logic [7:0] rf_rd_data,
  output logic [4:0] rf_rd_addr,
  output isle_pkg::isle_rf_wr_s rf_wr,
  output logic [7:0] acc,
  output logic null_result_flag,
  output logic skip_active,
  output logic retired
);
  isle_pkg::isle_state_s st;
  isle_pkg::isle_state_s next_st;
  logic inc_op;
  logic or_op;
  logic target;
  logic [4:0] addr;
  logic [7:0] imm;
  logic [7:0] inc_result;
  logic [7:0] or_result;

  isle_decode u_decode (
    .word(instr.word),
    .increment_skip_zero_op(inc_op),
    .or_immediate_op(or_op),
    .result_target_select(target),
    .register_operand(addr),
    .immediate_value(imm)
  );

  // The operand read address follows the word combinationally for the file.
  assign rf_rd_addr = addr;
  // [RULE7] Modulo-256 increment.
  assign inc_result = 8'(rf_rd_data + 8'h01);
  assign or_result = st.acc | imm;

  always_comb begin
    next_st = st;
    next_st.rf_wr.wr_en = 1'b0;
    next_st.retired = 1'b0;
    next_st.skip_active = 1'b0;
    next_st.state = isle_pkg::ISLE_EXEC;
    if (st.state == isle_pkg::ISLE_SKIP) begin
      // [RULE3] Prefetched word discarded.
      next_st.retired = 1'b1;
    end else if (instr.valid) begin
      case (1'b1)
        inc_op: begin
          next_st.retired = 1'b1;
          // [RULE2] Destination select.
          if (target) begin
            next_st.rf_wr.wr_en = 1'b1;
            next_st.rf_wr.addr = addr;
            next_st.rf_wr.data = inc_result;
          end else begin
            next_st.acc = inc_result;
          end
          // [RULE4] Skip on written value.
          if (inc_result == 8'h00) begin
            next_st.state = isle_pkg::ISLE_SKIP;
            next_st.skip_active = 1'b1;
          end
        end
        or_op: begin
          // [RULE6] Accumulator and flag update.
          next_st.acc = or_result;
          next_st.null_result_flag = or_result == 8'h00;
          next_st.retired = 1'b1;
        end
        default: begin
          next_st.retired = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '{state: isle_pkg::ISLE_IDLE, acc: `ISLE_ACC_RESET, null_result_flag: 1'b0,
              rf_wr: '{wr_en: 1'b0, addr: 5'h00, data: 8'h00}, skip_active: 1'b0, retired: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rf_wr = st.rf_wr;
  assign acc = st.acc;
  assign null_result_flag = st.null_result_flag;
  assign skip_active = st.skip_active;
  assign retired = st.retired;

  property p_inc_acc;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && !target) |=> acc == $past(inc_result);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment not written to accumulator"); // [RULE2]

  property p_inc_reg;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && target)
        |=> rf_wr.wr_en && rf_wr.data == $past(inc_result) && rf_wr.addr == $past(addr);
  endproperty
  a_inc_reg: assert property (p_inc_reg) else $error("increment not written to register"); // [RULE2]

  property p_skip;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && rf_rd_data == 8'hff)
        |=> skip_active ##1 (retired && !rf_wr.wr_en && $stable(acc) && $stable(null_result_flag));
  endproperty
  a_skip: assert property (p_skip) else $error("zero result did not skip next word"); // [RULE3]

  property p_noskip;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && rf_rd_data != 8'hff) |=> !skip_active;
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip on nonzero result"); // [RULE4]

  property p_inc_flag;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op) |=> $stable(null_result_flag);
  endproperty
  a_inc_flag: assert property (p_inc_flag) else $error("increment changed flag"); // [RULE3]

  property p_or;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && or_op)
        |=> acc == ($past(acc) | $past(imm)) && retired && !rf_wr.wr_en;
  endproperty
  a_or: assert property (p_or) else $error("or result wrong"); // [RULE6]

  property p_or_flag;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && or_op) |=> null_result_flag == (acc == 8'h00);
  endproperty
  a_or_flag: assert property (p_or_flag) else $error("zero flag wrong after or"); // [RULE7]

  property p_decode;
    @(posedge mclk) disable iff (reset)
      (instr.word[`ISLE_OPC6_MSB:`ISLE_OPC6_LSB] == `ISLE_INC_SKIP_OPC) |-> inc_op && !or_op;
  endproperty
  a_decode: assert property (p_decode) else $error("increment opcode not decoded"); // [RULE1]

  property p_decode_or;
    @(posedge mclk) disable iff (reset)
      (instr.word[`ISLE_OPC6_MSB:`ISLE_OPC4_LSB] == `ISLE_OR_IMM_OPC) |-> or_op && !inc_op;
  endproperty
  a_decode_or: assert property (p_decode_or) else $error("or opcode not decoded"); // [RULE5]

  property p_rd_addr;
    @(posedge mclk) disable iff (reset)
      instr.valid |-> rf_rd_addr == instr.word[`ISLE_ADDR_MSB:0];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("operand address not taken from word"); // [RULE1]

  property p_inc_keep_acc;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && target) |=> $stable(acc);
  endproperty
  a_inc_keep_acc: assert property (p_inc_keep_acc) else $error("register increment changed accumulator"); // [RULE2]

  property p_inc_no_wr;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && !target) |=> !rf_wr.wr_en;
  endproperty
  a_inc_no_wr: assert property (p_inc_no_wr) else $error("accumulator increment wrote register"); // [RULE2]

  property p_discard;
    @(posedge mclk) disable iff (reset)
      (st.state == isle_pkg::ISLE_SKIP)
        |=> retired && !skip_active && !rf_wr.wr_en && $stable(acc) && $stable(null_result_flag);
  endproperty
  a_discard: assert property (p_discard) else $error("prefetched word not discarded"); // [RULE3]

  property p_skip_once;
    @(posedge mclk) disable iff (reset)
      skip_active |=> !skip_active;
  endproperty
  a_skip_once: assert property (p_skip_once) else $error("skip lasted more than one cycle"); // [RULE3]

  property p_skip_written;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && !target && rf_rd_data == 8'hff)
        |=> acc == 8'h00 && skip_active;
  endproperty
  a_skip_written: assert property (p_skip_written) else $error("no skip on zero written to accumulator"); // [RULE4]

  property p_wrap;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && inc_op && target && rf_rd_data == 8'hff)
        |=> rf_wr.wr_en && rf_wr.data == 8'h00 && skip_active;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment did not wrap to zero"); // [RULE7]

  property p_or_single;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && or_op) |=> !skip_active;
  endproperty
  a_or_single: assert property (p_or_single) else $error("or took more than one cycle"); // [RULE6]

  property p_or_flag_set;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && or_op && (acc | instr.word[`ISLE_IMM_MSB:0]) == 8'h00)
        |=> null_result_flag;
  endproperty
  a_or_flag_set: assert property (p_or_flag_set) else $error("zero flag not set after or"); // [RULE7]

  property p_or_flag_clr;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid && or_op && (acc | instr.word[`ISLE_IMM_MSB:0]) != 8'h00)
        |=> !null_result_flag;
  endproperty
  a_or_flag_clr: assert property (p_or_flag_clr) else $error("zero flag not cleared after or"); // [RULE7]

  property p_refuse;
    @(posedge mclk) disable iff (reset)
      (st.state != isle_pkg::ISLE_SKIP && instr.valid
        && instr.word[`ISLE_OPC6_MSB:`ISLE_OPC6_LSB] != `ISLE_INC_SKIP_OPC
        && instr.word[`ISLE_OPC6_MSB:`ISLE_OPC4_LSB] != `ISLE_OR_IMM_OPC)
        |=> !retired && !rf_wr.wr_en && !skip_active && $stable(acc) && $stable(null_result_flag);
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign opcode changed state"); // [RULE5]
endmodule // isle_core

/* test/tb_increment_skip_or_literal_exec.sv */
module tb_increment_skip_or_literal_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  isle_pkg::isle_instr_s instr = '0;
  logic [7:0] rf [32];
  logic [7:0] rf_rd_data;
  logic [4:0] rf_rd_addr;
  isle_pkg::isle_rf_wr_s rf_wr;
  logic [7:0] acc;
  logic null_result_flag, skip_active, retired;
  int mismatches = 0;
  int checks_done = 0;
  always #50 mclk = ~mclk;
  assign rf_rd_data = rf[rf_rd_addr];
  isle_core DUT (.mclk(mclk), .reset(reset), .instr(instr), .rf_rd_data(rf_rd_data), .rf_rd_addr(rf_rd_addr),
    .rf_wr(rf_wr), .acc(acc), .null_result_flag(null_result_flag), .skip_active(skip_active), .retired(retired));
  task put(input logic v, input logic [11:0] w);
    @(posedge mclk);
    #10;
    instr = '{valid: v, word: w};
  endtask
  function automatic logic [7:0] st();
    return {4'h0, rf_wr.wr_en, null_result_flag, retired, skip_active};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task t_or();
    put(1'b1, 12'hd00);
    put(1'b0, 12'h000);
    chk(acc, 8'h00);
    chk(st(), 8'h06);
    put(1'b1, 12'hd9a);
    put(1'b1, 12'hd35);
    chk(acc, 8'h9a);
    put(1'b0, 12'h000);
    chk(acc, 8'hbf);
    chk(st(), 8'h02);
  endtask
  task t_inc();
    rf[3] = 8'h41;
    rf[31] = 8'h7f;
    put(1'b1, 12'h3c3);
    put(1'b1, 12'h3ff);
    chk(acc, 8'h42);
    chk(st(), 8'h02);
    put(1'b0, 12'h000);
    chk(st(), 8'h0a);
    chk({3'h0, rf_wr.addr}, 8'h1f);
    chk(rf_wr.data, 8'h80);
    chk(acc, 8'h42);
  endtask
  task t_skip();
    rf[31] = 8'hff;
    rf[0] = 8'hff;
    put(1'b1, 12'h3ff);
    put(1'b1, 12'hd01);
    chk(st(), 8'h0b);
    chk(rf_wr.data, 8'h00);
    put(1'b1, 12'h3c0);
    chk(st(), 8'h02);
    chk(acc, 8'h42);
    put(1'b1, 12'h3c3);
    chk(acc, 8'h00);
    chk(st(), 8'h03);
    put(1'b0, 12'h000);
    chk(acc, 8'h00);
    chk(st(), 8'h02);
  endtask
  task t_refuse();
    put(1'b1, 12'h2a5);
    put(1'b0, 12'hd55);
    chk(st(), 8'h00);
    put(1'b0, 12'h000);
    chk(st(), 8'h00);
    chk(acc, 8'h00);
  endtask
  task t_flag();
    put(1'b1, 12'hd00);
    put(1'b1, 12'h3c3);
    chk(st(), 8'h06);
    put(1'b0, 12'h000);
    chk(acc, 8'h42);
    chk(st(), 8'h06);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 32; i++) begin
      rf[i] = 8'h00;
    end
    repeat (12) @(posedge mclk);
    #10;
    reset = 1'b0;
    chk(acc, 8'h00);
    chk(st(), 8'h00);
    t_or();
    t_inc();
    t_skip();
    t_refuse();
    t_flag();
    stop_test();
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule // tb_increment_skip_or_literal_exec
